//--- logic/pm_pkg.sv
package pm_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_ERCNT  = 8'h04;
  localparam logic [7:0] A_CNT    = 8'h08;
  localparam logic [7:0] A_TXSEL  = 8'h28;
  localparam logic [7:0] A_RXSEL  = 8'h2C;
  localparam logic [7:0] A_TXMON  = 8'h30;
  localparam logic [7:0] A_RXMON  = 8'h34;
  localparam logic [7:0] A_STAT   = 8'h38;
  localparam logic [1:0] BANK_FIX = 2'h0;
  localparam logic [1:0] BANK_RS  = 2'h1;
  localparam logic [1:0] BANK_TS  = 2'h2;
  // control register fields
  localparam int CTRL_E1   = 0;
  localparam int CTRL_ESF  = 1;
  localparam int CTRL_CRC4 = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // error counter config fields
  localparam int ER_EXZ  = 0;
  localparam int ER_FBIT = 1;
  localparam int ER_FS   = 2;
  localparam int ER_CV   = 3;
  localparam int ER_UPD  = 4;
  localparam int ER_MAN  = 6;
  localparam logic [5:0] ER_RST = 6'h00;
  // counter indices
  localparam int NCNT  = 4;
  localparam int C_LCV = 0;
  localparam int C_PCV = 1;
  localparam int C_FOS = 2;
  localparam int C_EB  = 3;
  localparam int NSIG  = 16;
  // update source
  typedef enum logic [1:0] {
    PM_UPD_SEC   = 2'b00,
    PM_UPD_SHORT = 2'b01,
    PM_UPD_MAN   = 2'b10
  } pm_upd_t;
  typedef enum logic [1:0] {
    PM_BUS_IDLE = 2'b00,
    PM_BUS_RD   = 2'b01,
    PM_BUS_WR   = 2'b10
  } pm_bus_t;
  // timing
  localparam int CLK_NS      = 4;
  localparam int NS_PER_MS   = 1000000;
  localparam int SEC_MS      = 1000;
  localparam int T1_MS       = 42;
  localparam int E1_MS       = 62;
  localparam int SEC_CYCLES  = SEC_MS * NS_PER_MS / CLK_NS;
  localparam int T1_CYCLES   = T1_MS * NS_PER_MS / CLK_NS;
  localparam int E1_CYCLES   = E1_MS * NS_PER_MS / CLK_NS;
  localparam int TMR_W       = 28;
endpackage

//--- logic/pm_perf_mon.sv
`timescale 1ns/1ps
// Operation
// - e1 line-code counter counts bipolar violations if select 0, code violations if 1
// - t1 esf: path counter counts each crc6 word in error
// - t1 d4: path counter counts ft errors, plus fs errors when bit 2 set
// - t1: path counter halts while receive loss of sync is high
// - e1: path counter counts crc4 errors, holds on fas/crc4 loss, not cas loss
// - path count is 16 bits, high register then low register
// - t1 mos select: count out-of-sync multiframes, even during loss of sync
// - t1 f-bit select: count ft (d4) or fps (esf) errors, halt on loss of sync
// - e1: count fas word errors, not during loss of sync, fas/crc4 loss or cas loss
// - out-of-sync count is 16 bits, high register then low register
// - e1 crc4: block error counter counts each received e-bit of zero
// - block error count is 16 bits, high register holds upper part
// - block error counter pauses on fas/crc4 loss, counts on cas loss only
// - one tx and one rx channel captured at once, 5-bit selects, own registers
// - signaling reachable by 16+16 registers and by pins, concurrently
// - all error counters saturate, never wrap
// - counters update on one second, 42/62 ms, or manual request
module pm_perf_mon
  import pm_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES,
  parameter int T1_CYC  = T1_CYCLES,
  parameter int E1_CYC  = E1_CYCLES
)(
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // receive framer events, one-cycle pulses
  input  wire logic               bpv_ev,
  input  wire logic               cv_ev,
  input  wire logic               exz_ev,
  input  wire logic               crc6_err_ev,
  input  wire logic               ft_err_ev,
  input  wire logic               fs_err_ev,
  input  wire logic               fps_err_ev,
  input  wire logic               crc4_err_ev,
  input  wire logic               fas_err_ev,
  input  wire logic               ebit_zero_ev,
  input  wire logic               mf_boundary_ev,
  // receive framer sync levels
  input  wire logic               receive_loss_of_sync,
  input  wire logic               multiframe_out_of_sync,
  input  wire logic               fas_sync_lost,
  input  wire logic               crc4_mf_lost,
  input  wire logic               cas_mf_lost,
  // channel byte streams
  input  wire logic               tx_slot_done,
  input  wire logic [4:0]         tx_slot_num,
  input  wire logic [7:0]         tx_slot_byte,
  input  wire logic               rx_slot_done,
  input  wire logic [4:0]         rx_slot_num,
  input  wire logic [7:0]         rx_slot_byte,
  // signaling hardware path
  input  wire logic               rx_sig_wr,
  input  wire logic [3:0]         rx_sig_idx,
  input  wire logic [7:0]         rx_sig_data,
  input  wire logic [3:0]         rx_sig_pin_idx,
  output logic      [7:0]         rx_signaling_pin,
  input  wire logic               tx_sig_pin_wr,
  input  wire logic [3:0]         tx_sig_pin_idx,
  input  wire logic [7:0]         tx_signaling_pin,
  output logic      [NSIG*8-1:0]  tx_sig_regs
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  pm_bus_t     bus_q;
  logic [7:0]  adr_q;
  logic        rdy_q;
  logic [31:0] rd_q;
  logic [31:0] rd_word;

  // reads take one wait state so hrdata comes from a flop
  wire take   = hsel & hready & htrans[1];
  wire wr_now = (bus_q == PM_BUS_WR);
  wire [1:0] bank = adr_q[7:6];
  wire [3:0] sidx = adr_q[5:2];
  wire fix_wr = wr_now & (bank == BANK_FIX);
  wire ctrl_wr  = fix_wr & (adr_q == A_CTRL);
  wire er_wr    = fix_wr & (adr_q == A_ERCNT);
  wire txsel_wr = fix_wr & (adr_q == A_TXSEL);
  wire rxsel_wr = fix_wr & (adr_q == A_RXSEL);
  wire ts_wr    = wr_now & (bank == BANK_TS);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_q <= PM_BUS_IDLE;
      adr_q <= 8'h00;
      rdy_q <= 1'b0;
      rd_q  <= 32'h0000_0000;
    end
    else
    begin
      rdy_q <= 1'b1;
      if (bus_q == PM_BUS_RD)
      begin
        rd_q  <= rd_word;
        bus_q <= PM_BUS_IDLE;
      end
      else if (take)
      begin
        adr_q <= haddr[7:0];
        bus_q <= hwrite ? PM_BUS_WR : PM_BUS_RD;
        rdy_q <= hwrite;
      end
      else
        bus_q <= PM_BUS_IDLE;
    end
  end

  assign hrdata    = rd_q;
  assign hreadyout = rdy_q;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [2:0]  ctrl_q;
  logic [5:0]  er_q;
  logic        man_q;
  logic [4:0]  txsel_q;
  logic [4:0]  rxsel_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q  <= CTRL_RST;
      er_q    <= ER_RST;
      man_q   <= 1'b0;
      txsel_q <= 5'h00;
      rxsel_q <= 5'h00;
    end
    else
    begin
      if (ctrl_wr)
        ctrl_q <= hwdata[2:0];
      if (er_wr)
        er_q <= hwdata[5:0];
      man_q <= er_wr & hwdata[ER_MAN];  // self-clearing request
      if (txsel_wr)
        txsel_q <= hwdata[4:0];
      if (rxsel_wr)
        rxsel_q <= hwdata[4:0];
    end
  end

  wire     e1   = ctrl_q[CTRL_E1];
  wire     esf  = ctrl_q[CTRL_ESF];
  wire     crc4 = ctrl_q[CTRL_CRC4];
  pm_upd_t upd;
  assign   upd  = pm_upd_t'(er_q[ER_UPD +: 2]);

  ////////////////////////////////////////////////////////////////////////////
  // update timer
  logic [TMR_W-1:0] tmr_q;

  wire [TMR_W-1:0] lim = (upd == PM_UPD_SEC) ? TMR_W'(SEC_CYC - 1)
                       : e1 ? TMR_W'(E1_CYC - 1) : TMR_W'(T1_CYC - 1);
  wire tick  = (tmr_q >= lim);
  wire latch = (tick & (upd != PM_UPD_MAN)) | man_q;

  // restart the period on any mode change so the first period is whole
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tmr_q <= '0;
    else if (tick | ctrl_wr | er_wr)
      tmr_q <= '0;
    else
      tmr_q <= tmr_q + TMR_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // counting conditions
  wire e1_hold = fas_sync_lost | crc4_mf_lost;  // cas loss alone keeps the path and block error counts running
  wire t1_d4fr = ft_err_ev | (er_q[ER_FS] & fs_err_ev);
  wire t1_pcv  = ~receive_loss_of_sync & (esf ? crc6_err_ev : t1_d4fr);
  wire e1_pcv  = crc4_err_ev & ~e1_hold;
  wire t1_fbit = ~receive_loss_of_sync & (esf ? fps_err_ev : ft_err_ev);
  wire t1_mos  = mf_boundary_ev & multiframe_out_of_sync;
  wire t1_fos  = er_q[ER_FBIT] ? t1_fbit : t1_mos;
  wire e1_fos  = fas_err_ev & ~receive_loss_of_sync & ~e1_hold & ~cas_mf_lost;
  wire e1_lcv  = er_q[ER_CV] ? cv_ev : bpv_ev;
  wire t1_lcv  = bpv_ev | (er_q[ER_EXZ] & exz_ev);

  wire [NCNT-1:0] inc;
  assign inc[C_LCV] = e1 ? e1_lcv : t1_lcv;
  assign inc[C_PCV] = e1 ? e1_pcv : t1_pcv;
  assign inc[C_FOS] = e1 ? e1_fos : t1_fos;
  assign inc[C_EB]  = e1 & crc4 & ebit_zero_ev & ~e1_hold;

  ////////////////////////////////////////////////////////////////////////////
  // running counters and host snapshots
  logic [15:0] run_q  [NCNT];
  logic [15:0] snap_q [NCNT];

  genvar gi;
  generate
    for (gi = 0; gi < NCNT; gi++)
    begin : g_cnt
      wire full = &run_q[gi];
      // an event in the latch cycle starts the next period
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          run_q[gi]  <= 16'h0000;
          snap_q[gi] <= 16'h0000;
        end
        else if (latch)
        begin
          snap_q[gi] <= run_q[gi];
          run_q[gi]  <= {15'h0000, inc[gi]};
        end
        else if (inc[gi] & ~full)
          run_q[gi] <= run_q[gi] + 16'h0001;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // channel monitors
  logic [7:0] txmon_q;
  logic [7:0] rxmon_q;

  // out-of-range selects never match, so the monitor simply holds
  wire tx_hit = tx_slot_done & (tx_slot_num == txsel_q);
  wire rx_hit = rx_slot_done & (rx_slot_num == rxsel_q);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      txmon_q <= 8'h00;
      rxmon_q <= 8'h00;
    end
    else
    begin
      if (tx_hit)
        txmon_q <= tx_slot_byte;
      if (rx_hit)
        rxmon_q <= rx_slot_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // signaling registers, both paths live at once
  logic [7:0] rs_q [NSIG];
  logic [7:0] ts_q [NSIG];
  logic [7:0] rsp_q;

  generate
    for (gi = 0; gi < NSIG; gi++)
    begin : g_sig
      // host write beats a pin write to the same entry
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          rs_q[gi] <= 8'h00;
          ts_q[gi] <= 8'h00;
        end
        else
        begin
          if (rx_sig_wr & (rx_sig_idx == 4'(gi)))
            rs_q[gi] <= rx_sig_data;
          if (ts_wr & (sidx == 4'(gi)))
            ts_q[gi] <= hwdata[7:0];
          else if (tx_sig_pin_wr & (tx_sig_pin_idx == 4'(gi)))
            ts_q[gi] <= tx_signaling_pin;
        end
      end
      assign tx_sig_regs[gi*8 +: 8] = ts_q[gi];
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rsp_q <= 8'h00;
    else
      rsp_q <= rs_q[rx_sig_pin_idx];
  end

  assign rx_signaling_pin = rsp_q;

  ////////////////////////////////////////////////////////////////////////////
  // read mux; each count reads as high byte register then low byte register
  wire [2:0]  cnt_sel = 3'((adr_q - A_CNT) >> 3);
  wire        cnt_lo  = adr_q[2];
  wire        in_cnt  = (adr_q >= A_CNT) & (adr_q < A_TXSEL);
  wire [15:0] cnt_val = snap_q[cnt_sel[1:0]];
  wire [7:0]  cnt_byte = cnt_lo ? cnt_val[7:0] : cnt_val[15:8];
  wire [7:0]  stat = {3'h0, cas_mf_lost, crc4_mf_lost, fas_sync_lost,
                      multiframe_out_of_sync, receive_loss_of_sync};

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (bank)
      BANK_RS: rd_word = {24'h000000, rs_q[sidx]};
      BANK_TS: rd_word = {24'h000000, ts_q[sidx]};
      BANK_FIX:
      begin
        if (in_cnt)
          rd_word = {24'h000000, cnt_byte};
        else
          case (adr_q)
            A_CTRL:  rd_word = {29'h0, ctrl_q};
            A_ERCNT: rd_word = {26'h0, er_q};
            A_TXSEL: rd_word = {27'h0, txsel_q};
            A_RXSEL: rd_word = {27'h0, rxsel_q};
            A_TXMON: rd_word = {24'h000000, txmon_q};
            A_RXMON: rd_word = {24'h000000, rxmon_q};
            A_STAT:  rd_word = {24'h000000, stat};
            default: rd_word = 32'h0000_0000;
          endcase
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

endmodule

//--- testbench/pm_perf_mon_asserts.sv
`timescale 1ns/1ps
module pm_perf_mon_asserts
  import pm_pkg::*;
(
  // clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // bus
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // signaling
  input wire logic              rx_sig_wr,
  input wire logic [3:0]        rx_sig_idx,
  input wire logic [7:0]        rx_sig_data,
  input wire logic [3:0]        rx_sig_pin_idx,
  input wire logic [7:0]        rx_signaling_pin,
  input wire logic              tx_sig_pin_wr,
  input wire logic [3:0]        tx_sig_pin_idx,
  input wire logic [7:0]        tx_signaling_pin,
  input wire logic [NSIG*8-1:0] tx_sig_regs
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // taken request and data-phase flags
  wire  tk = hsel && hready && htrans[1];
  logic rd_q;
  logic wr_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      rd_q <= tk && !hwrite;
      wr_q <= tk && hwrite;
    end
  end
  ////////////////////////////////////////
  sequence s_rd;
    tk && !hwrite;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (s_rd |=> s_wait)
    else $error("read not answered after one wait state");
  a_write_nowait: assert property (tk && hwrite |=> hreadyout)
    else $error("write stalled");
  a_ready_cause: assert property ($fell(hreadyout) |-> $past(tk && !hwrite))
    else $error("wait state without a read");
  // keyed on the falling edge so the low level left over from reset is not taken as a wait
  a_ready_single: assert property ($fell(hreadyout) |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_unmapped_zero: assert property (tk && !hwrite && haddr[7:0] == 8'hFC |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  // read data may only move at the end of a read wait state
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_q))
    else $error("read data moved outside a read");
  // host write in the same cycle wins, so those cycles are left out
  a_txpin_write: assert property (tx_sig_pin_wr && !wr_q |=>
    tx_sig_regs[$past(tx_sig_pin_idx)*8 +: 8] == $past(tx_signaling_pin))
    else $error("tx signaling pin write lost");
  a_rxpin_show: assert property (rx_sig_wr && rx_sig_idx == rx_sig_pin_idx ##1
    (!rx_sig_wr && $stable(rx_sig_pin_idx)) |=> rx_signaling_pin == $past(rx_sig_data, 2))
    else $error("rx signaling pin stale");
endmodule
bind pm_perf_mon pm_perf_mon_asserts u_chk (.*);

//--- testbench/pm_frm_model.sv
`timescale 1ns/1ps
module pm_frm_model (
  // clock
  input wire logic hclk,
  // events {mf,ebit,fas,crc4,fps,fs,ft,crc6,exz,cv,bpv}
  output logic [10:0] ev,
  // sync levels {cas,crc4,fas,mos,rloss}
  output logic [4:0]  sy,
  // slot streams, both directions on one timing
  output logic        slot_done,
  output logic [4:0]  slot_num,
  output logic [7:0]  tx_byte,
  output logic [7:0]  rx_byte
);
  // quiet framer at time zero
  initial
  begin
    {ev, sy, slot_done, slot_num, tx_byte, rx_byte} = '0;
  end
  // n single-cycle events with a gap so each is a clean pulse
  task automatic pulse(input int k, input int n);
    repeat (n)
    begin
      ev <= 11'h001 << k;
      @(posedge hclk);
      ev <= '0;
      @(posedge hclk);
    end
  endtask
  // event on every cycle, the fastest the framer can report
  task automatic hold(input int k, input int n);
    ev <= 11'h001 << k;
    repeat (n) @(posedge hclk);
    ev <= '0;
    @(posedge hclk);
  endtask
  task automatic lv(input logic [4:0] v);
    sy <= v;
    @(posedge hclk);
  endtask
  // one frame of 32 slots; bytes turn over once released
  task automatic frame();
    for (int s = 0; s < 32; s++)
    begin
      slot_done <= 1'b1;
      slot_num  <= 5'(s);
      tx_byte   <= 8'(s) ^ 8'hA5;
      rx_byte   <= 8'(s) + 8'h30;
      @(posedge hclk);
    end
    slot_done <= 1'b0;
    tx_byte   <= ~tx_byte;
    rx_byte   <= ~rx_byte;
    @(posedge hclk);
  endtask
endmodule

//--- testbench/test_pm_perf_mon.sv
`timescale 1ns/1ps
module test_pm_perf_mon
  import pm_pkg::*;
;
  logic              hclk, hresetn, hsel, hwrite, rx_sig_wr, tx_sig_pin_wr;
  logic              hreadyout, hresp, slot_done, rdy_s;
  logic [31:0]       haddr, hwdata, hrdata, q, rd_s, er;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [3:0]        rx_sig_idx, rx_sig_pin_idx, tx_sig_pin_idx;
  logic [7:0]        rx_sig_data, tx_signaling_pin, rx_signaling_pin, tx_byte, rx_byte;
  logic [4:0]        sy, slot_num;
  logic [10:0]       ev;
  logic [NSIG*8-1:0] tx_sig_regs;
  int                n_fail, n_checks, cyc, s;
  pm_frm_model u_frm (.*);
  pm_perf_mon #(.SEC_CYC(40), .T1_CYC(20), .E1_CYC(30)) u_dut (
    .*, .hready(hreadyout),
    .bpv_ev(ev[0]), .cv_ev(ev[1]), .exz_ev(ev[2]), .crc6_err_ev(ev[3]),
    .ft_err_ev(ev[4]), .fs_err_ev(ev[5]), .fps_err_ev(ev[6]), .crc4_err_ev(ev[7]),
    .fas_err_ev(ev[8]), .ebit_zero_ev(ev[9]), .mf_boundary_ev(ev[10]),
    .receive_loss_of_sync(sy[0]), .multiframe_out_of_sync(sy[1]), .fas_sync_lost(sy[2]),
    .crc4_mf_lost(sy[3]), .cas_mf_lost(sy[4]),
    .tx_slot_done(slot_done), .tx_slot_num(slot_num), .tx_slot_byte(tx_byte),
    .rx_slot_done(slot_done), .rx_slot_num(slot_num), .rx_slot_byte(rx_byte));
  ////////////////////////////////////////
  always #2 hclk = ~hclk;
  // mid-cycle copies avoid racing the edge that updates them
  always @(negedge hclk)
  begin
    rdy_s = hreadyout;
    rd_s  = hrdata;
  end
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single transfer; waits only on the slave's ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (rdy_s !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (rdy_s !== 1'b1);
    q = rd_s;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // manual snapshot; the config write also restarts the timer
  task automatic upd();
    wr(A_ERCNT, er | 32'h40);
  endtask
  task automatic mode(input logic [31:0] c, input logic [31:0] e);
    wr(A_CTRL, c);
    er = e;
    upd();
  endtask
  // high byte at the lower address
  task automatic cnt(input int k, input logic [15:0] e);
    rd(8'(A_CNT + 8 * k), {24'h0, e[15:8]});
    rd(8'(A_CNT + 8 * k + 4), {24'h0, e[7:0]});
  endtask
  ////////////////////////////////////////
  initial
  begin
    {hclk, hresetn, hsel, hwrite, rx_sig_wr, tx_sig_pin_wr} = '0;
    {haddr, hwdata, htrans, hsize, er, n_fail, n_checks, cyc} = '0;
    {rx_sig_idx, rx_sig_pin_idx, tx_sig_pin_idx, rx_sig_data, tx_signaling_pin} = '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(A_CTRL, 32'h0);
    rd(A_ERCNT, 32'h0);
    u_frm.lv(5'h15);
    rd(A_STAT, 32'h15);
    // status read first so the unmapped read has to pull hrdata back to zero
    wr(8'hFC, 32'h1);
    rd(8'hFC, 32'h0);
    // sync levels back to normal, loss of sync would mask the t1 path counts
    u_frm.lv(5'h00);
    $display("test reset finished");
    mode(32'h0, 32'h20);
    u_frm.pulse(0, 4);
    u_frm.pulse(4, 3);
    u_frm.pulse(5, 2);
    u_frm.lv(5'h02);
    u_frm.pulse(10, 2);
    u_frm.lv(5'h00);
    u_frm.pulse(10, 1);
    upd();
    cnt(C_LCV, 16'd4);
    cnt(C_PCV, 16'd3);
    cnt(C_FOS, 16'd2);
    upd();
    cnt(C_PCV, 16'd0);
    mode(32'h0, 32'h24);
    u_frm.pulse(4, 1);
    u_frm.pulse(5, 2);
    u_frm.lv(5'h01);
    u_frm.pulse(4, 2);
    u_frm.lv(5'h03);
    u_frm.pulse(10, 1);
    u_frm.lv(5'h00);
    upd();
    cnt(C_PCV, 16'd3);
    cnt(C_FOS, 16'd1);
    mode(32'h2, 32'h22);
    u_frm.pulse(3, 2);
    u_frm.pulse(4, 1);
    u_frm.pulse(6, 3);
    u_frm.lv(5'h01);
    u_frm.pulse(6, 1);
    u_frm.pulse(3, 1);
    u_frm.lv(5'h00);
    upd();
    cnt(C_PCV, 16'd2);
    cnt(C_FOS, 16'd3);
    $display("test t1 counters finished");
    mode(32'h5, 32'h28);
    u_frm.pulse(0, 2);
    u_frm.pulse(1, 3);
    u_frm.pulse(7, 2);
    u_frm.pulse(9, 2);
    u_frm.pulse(8, 2);
    for (int i = 0; i < 3; i++)
    begin
      u_frm.lv(5'(16 >> i));
      u_frm.pulse(7, 1);
      u_frm.pulse(9, 1);
      u_frm.pulse(8, 1);
    end
    // loss of sync alone must still block the alignment word count
    u_frm.lv(5'h01);
    u_frm.pulse(8, 1);
    u_frm.lv(5'h00);
    upd();
    cnt(C_LCV, 16'd3);
    cnt(C_PCV, 16'd3);
    cnt(C_FOS, 16'd2);
    cnt(C_EB, 16'd3);
    mode(32'h1, 32'h20);
    u_frm.pulse(9, 1);
    upd();
    cnt(C_EB, 16'd0);
    $display("test e1 counters finished");
    mode(32'h0, 32'h10);
    u_frm.pulse(0, 1);
    repeat (20) @(posedge hclk);
    cnt(C_LCV, 16'd1);
    mode(32'h0, 32'h20);
    u_frm.hold(0, 65540);
    upd();
    cnt(C_LCV, 16'hFFFF);
    $display("test timer and saturation finished");
    wr(A_CTRL, 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      s = i * 26 + 5;
      wr(A_TXSEL, 32'(s));
      wr(A_RXSEL, 32'(31 - s));
      u_frm.frame();
      rd(A_TXSEL, 32'(s));
      rd(A_TXMON, 32'(s) ^ 32'hA5);
      rd(A_RXMON, 32'(31 - s) + 32'h30);
    end
    $display("test monitors finished");
    rx_sig_idx     <= 4'h3;
    rx_sig_pin_idx <= 4'h3;
    rx_sig_data    <= 8'h5A;
    rx_sig_wr      <= 1'b1;
    tx_sig_pin_idx <= 4'h2;
    tx_signaling_pin <= 8'hC3;
    tx_sig_pin_wr  <= 1'b1;
    @(posedge hclk);
    rx_sig_wr      <= 1'b0;
    tx_sig_pin_wr  <= 1'b0;
    rx_sig_data    <= 8'hA5;
    repeat (3) @(posedge hclk);
    chk(32'(rx_signaling_pin), 32'h5A);
    wr(8'h4C, 32'h0);
    rd(8'h4C, 32'h5A);
    rd(8'h88, 32'hC3);
    wr(8'h84, 32'h96);
    // the write lands on the edge the task returns at, so look mid-cycle
    @(negedge hclk);
    chk(32'(tx_sig_regs[15:8]), 32'h96);
    chk(32'(tx_sig_regs[23:16]), 32'hC3);
    $display("test signaling finished");
    report_and_stop();
  end
endmodule
